/* File: logic/i2cto_pkg.sv */
// Shared constants and types for the I2C slave data and time-out block
package i2cto_pkg;
    // Register byte offsets on the APB
    localparam int unsigned APB_AW    = 8;
    localparam logic [7:0]  OFF_DATA  = 8'h00;
    localparam logic [7:0]  OFF_ADDR  = 8'h04;
    localparam logic [7:0]  OFF_CTL0  = 8'h08;
    localparam logic [7:0]  OFF_CTL1  = 8'h0C;
    localparam logic [7:0]  OFF_TOC   = 8'h10;
    // Time-out control fields
    localparam int unsigned TOC_EN    = 7;
    localparam int unsigned TOC_FLAG  = 6;
    localparam int unsigned TOC_SELW  = 6;
    // First control register fields
    localparam int unsigned C0_EN     = 0;
    // Second control register fields
    localparam int unsigned C1_RECEIVED_ACK_STATUS   = 0;
    localparam int unsigned C1_SENT_ACK_BIT   = 1;
    localparam int unsigned C1_SRW    = 2;
    localparam int unsigned C1_HTX    = 3;
    localparam int unsigned C1_BUSY   = 4;
    localparam int unsigned C1_ADDRESS_MATCH_FLAG   = 6;
    // Reset values
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam logic [7:0]  ADDR_RST  = 8'h00;
    localparam logic [7:0]  TOC_RST   = 8'h00;
    // Bits per byte and sub-oscillator prescale
    localparam logic [3:0]  BYTE_BITS = 4'h8;
    localparam int unsigned SUB_DIV   = 32;
    localparam int unsigned PRE_W     = $clog2(SUB_DIV);
    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_ADDR    = 4'b0001,
        ST_ADDR_AK = 4'b0010,
        ST_STRETCH = 4'b0011,
        ST_RX      = 4'b0100,
        ST_RX_AK   = 4'b0101,
        ST_TX      = 4'b0110,
        ST_TX_AK   = 4'b0111,
        ST_WAIT_SP = 4'b1000
    } i2cto_state_t;
endpackage

/* File: logic/i2cto_sync.sv */
// Two flip-flop synchroniser for pin inputs
module i2cto_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // i2cto_sync

/* File: logic/i2cto_timeout.sv */
// Bus time-out counter paced by the sub-oscillator divided by 32
module i2cto_timeout (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Synchronised sub-oscillator level
    input  wire logic  sub_clk_s,
    // Control from the serial engine
    i2cto_to_if.cnt    to
);
    import i2cto_pkg::*;

    logic             sub_prev_q;
    logic [PRE_W-1:0] pre_q;
    logic [TOC_SELW:0] ticks_q;
    logic             expire_q;
    logic             sub_tick;
    logic [TOC_SELW:0] limit;

    assign sub_tick  = sub_clk_s & ~sub_prev_q;
    assign limit     = {1'b0, to.sel} + 7'h01;
    assign to.expire = expire_q;

    // Edge finder on the already synchronised level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sub_prev_q <= 1'b0;
        else        sub_prev_q <= sub_clk_s;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q   <= '0;
            ticks_q <= '0;
        end else if (!to.run || to.clr) begin
            pre_q   <= '0;
            ticks_q <= '0;
        end else if (sub_tick) begin
            pre_q <= pre_q + 1'b1;
            if (pre_q == PRE_W'(SUB_DIV - 1)) ticks_q <= ticks_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) expire_q <= 1'b0;
        else        expire_q <= to.run & ~to.clr & ~expire_q & (ticks_q == limit);
    end
endmodule // i2cto_timeout

/* File: logic/i2cto_to_if.sv */
// Link between serial engine and time-out counter
interface i2cto_to_if;
    import i2cto_pkg::*;
    logic                run;
    logic                clr;
    logic [TOC_SELW-1:0] sel;
    logic                expire;
    modport ctrl (output run, output clr, output sel, input expire);
    modport cnt  (input run, input clr, input sel, output expire);
endinterface

/* File: logic/i2cto_top.sv */
// I2C slave byte transfer with bus time-out, APB register access
// Functional notes
// - Bytes are eight bits, sent only after the slave acknowledged its address.
// - Bits shift most significant first, least significant last.
// - When receiving, the slave drives its acknowledge on the ninth clock.
// - Without master acknowledge the transmitting slave releases SDA for STOP.
// - The transmitted byte comes from the data register written by software.
// - Each received byte lands in the data register for software.
// - After address match SCL is held low until software services data.
// - Transmitter uses received-acknowledge status to continue or release SDA.
// - Time-out count starts on START plus match, cleared by SCL fall.
// - Time-out fires when SCL low interval exceeds the selected period.
// - A STOP condition halts time-out counting.
// - On overflow the counter stops, enable clears, flag sets.
// - Time-out raises the same interrupt as the serial bus.
// - Time-out resets serial logic and second control register only.
// - Software clears the time-out flag by writing it.
// - Period is select plus one times 32 sub-oscillator periods.
// - Time-out register: enable bit 7, flag bit 6, select bits 5..0.
// - Read/write bit after the address sets the direction status bit.
module i2cto_top (
    // Clock and reset
    input  wire logic                         MCLK,
    input  wire logic                         RESETN,
    // APB slave
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [i2cto_pkg::APB_AW-1:0] PADDR,
    input  wire logic [31:0]                  PWDATA,
    output logic      [31:0]                  PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    // I2C pins, open drain
    input  wire logic                         SCL_IN,
    output logic                              SCL_OUT,
    output logic                              SCL_OE,
    input  wire logic                         SDA_IN,
    output logic                              SDA_OUT,
    output logic                              SDA_OE,
    // Sub-oscillator clock, sampled as a level
    input  wire logic                         SUB_CLK,
    // Serial bus interrupt pulse
    output logic                              SIM_IRQ
);
    import i2cto_pkg::*;

    // Synchronised pins
    logic [2:0]          pins_s;
    logic                scl_s;
    logic                sda_s;
    logic                sub_s;
    logic                scl_p_q;
    logic                sda_p_q;
    logic                scl_rise;
    logic                scl_fall;
    logic                bus_start;
    logic                bus_stop;

    // Registers
    logic [7:0]          data_q;
    logic [7:0]          addr_q;
    logic                en_q;
    logic                htx_q;
    logic                sent_ack_bit_q;
    logic                received_ack_status_q;
    logic                srw_q;
    logic                address_match_flag_q;
    logic                toc_en_q;
    logic                toc_flag_q;
    logic [TOC_SELW-1:0] toc_sel_q;

    // Serial engine
    i2cto_state_t        state_q;
    logic [7:0]          shift_q;
    logic [3:0]          cnt_q;
    logic                rx_load_q;
    logic                to_run_q;
    logic                scl_oe_q;
    logic                sda_oe_q;
    logic                irq_q;

    // APB
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic                acc;
    logic                wr_en;
    logic                rd_en;
    logic                hit;
    logic [7:0]          rd_val;
    logic                wr_data;
    logic                rd_data;
    logic                to_expire;

    i2cto_to_if to_if ();

    // pins and sub clock synchronised
    // Bus pins pass inverted so the flops' zero reset equals an idle high bus;
    // otherwise a false SCL fall would follow every reset release
    i2cto_sync #(.W(3)) u_sync (
        .clk   (MCLK),
        .rst_n (RESETN),
        .d     ({SUB_CLK, ~SDA_IN, ~SCL_IN}),
        .q     (pins_s)
    );

    assign scl_s = ~pins_s[0];
    assign sda_s = ~pins_s[1];
    assign sub_s = pins_s[2];

    i2cto_timeout u_timeout (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .sub_clk_s (sub_s),
        .to        (to_if.cnt)
    );

    // counting halts outside a matched transfer
    assign to_if.run = to_run_q & toc_en_q;
    // each SCL fall restarts the period
    assign to_if.clr = scl_fall;
    assign to_if.sel = toc_sel_q;
    assign to_expire = to_if.expire;

    // Outputs; open drain pins only ever pull low
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE  = scl_oe_q;
    assign SDA_OE  = sda_oe_q;
    assign SIM_IRQ = irq_q;
    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA  = prdata_q;

    // Previous pin levels for edge and condition finding
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // APB decode; access completes in the first access cycle
    assign acc     = PSEL & PENABLE & pready_q;
    assign wr_en   = acc & PWRITE & hit;
    assign rd_en   = acc & ~PWRITE & hit;
    assign wr_data = wr_en & (PADDR == OFF_DATA);
    assign rd_data = rd_en & (PADDR == OFF_DATA);

    // Read multiplexer; reserved bits read zero
    always_comb begin
        hit    = 1'b1;
        rd_val = 8'h00;
        case (PADDR)
            OFF_DATA: rd_val = data_q;
            OFF_ADDR: rd_val = addr_q;
            OFF_CTL0: rd_val[C0_EN] = en_q;
            OFF_CTL1: begin
                rd_val[C1_RECEIVED_ACK_STATUS] = received_ack_status_q;
                rd_val[C1_SENT_ACK_BIT] = sent_ack_bit_q;
                rd_val[C1_SRW]  = srw_q;
                rd_val[C1_HTX]  = htx_q;
                rd_val[C1_BUSY] = (state_q != ST_IDLE);
                rd_val[C1_ADDRESS_MATCH_FLAG] = address_match_flag_q;
            end
            OFF_TOC: rd_val = {toc_en_q, toc_flag_q, toc_sel_q};
            default: hit = 1'b0;
        endcase
    end

    // Ready, error and read data registered at the setup cycle
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= PSEL & ~PENABLE;
            pslverr_q <= PSEL & ~PENABLE & ~hit;
            prdata_q  <= (PSEL & ~PENABLE & ~PWRITE) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // Address and enable keep their value through a time-out
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_q <= ADDR_RST;
            en_q   <= 1'b0;
        end else if (wr_en) begin
            if (PADDR == OFF_ADDR) addr_q <= PWDATA[7:0];
            if (PADDR == OFF_CTL0) en_q <= PWDATA[C0_EN];
        end
    end

    // Data register shared by software and receiver
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            data_q <= DATA_RST;
        end else if (rx_load_q) begin
            data_q <= shift_q;
        end else if (wr_data) begin
            data_q <= PWDATA[7:0];
        end
    end

    // Writable bits of the second control register
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            htx_q  <= 1'b0;
            sent_ack_bit_q <= 1'b0;
        end else if (to_expire) begin
            htx_q  <= 1'b0;
            sent_ack_bit_q <= 1'b0;
        end else if (wr_en && PADDR == OFF_CTL1) begin
            htx_q  <= PWDATA[C1_HTX];
            sent_ack_bit_q <= PWDATA[C1_SENT_ACK_BIT];
        end
    end

    // Time-out register; hardware set wins over software clear
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {toc_en_q, toc_flag_q, toc_sel_q} <= TOC_RST;
        end else begin
            if (wr_en && PADDR == OFF_TOC) begin
                toc_en_q   <= PWDATA[TOC_EN];
                toc_flag_q <= PWDATA[TOC_FLAG];
                toc_sel_q  <= PWDATA[TOC_SELW-1:0];
            end
            if (to_expire) begin
                toc_en_q   <= 1'b0;
                toc_flag_q <= 1'b1;
            end
        end
    end

    // Serial engine: sample on SCL rise, change SDA after SCL fall
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q   <= ST_IDLE;
            shift_q   <= 8'h00;
            cnt_q     <= 4'h0;
            rx_load_q <= 1'b0;
            to_run_q  <= 1'b0;
            scl_oe_q  <= 1'b0;
            sda_oe_q  <= 1'b0;
            received_ack_status_q    <= 1'b0;
            srw_q     <= 1'b0;
            address_match_flag_q    <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            rx_load_q <= 1'b0;
            irq_q     <= 1'b0;
            if (to_expire) begin
                state_q  <= ST_IDLE;
                to_run_q <= 1'b0;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                received_ack_status_q   <= 1'b0;
                srw_q    <= 1'b0;
                address_match_flag_q   <= 1'b0;
                irq_q    <= 1'b1;
            end else if (!en_q || bus_stop) begin
                state_q  <= ST_IDLE;
                to_run_q <= 1'b0;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                address_match_flag_q   <= 1'b0;
            end else if (bus_start) begin
                state_q  <= ST_ADDR;
                cnt_q    <= 4'h0;
                to_run_q <= 1'b0;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                address_match_flag_q   <= 1'b0;
            end else begin
                case (state_q)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == BYTE_BITS) begin
                            if (shift_q[7:1] == addr_q[7:1]) begin
                                srw_q    <= shift_q[0];
                                address_match_flag_q   <= 1'b1;
                                sda_oe_q <= 1'b1;
                                to_run_q <= 1'b1;
                                irq_q    <= 1'b1;
                                state_q  <= ST_ADDR_AK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_AK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            scl_oe_q <= 1'b1;
                            state_q  <= ST_STRETCH;
                        end
                    end
                    ST_STRETCH: begin
                        if (htx_q && wr_data) begin
                            shift_q  <= PWDATA[7:0];
                            sda_oe_q <= ~PWDATA[7];
                            scl_oe_q <= 1'b0;
                            cnt_q    <= 4'h0;
                            state_q  <= ST_TX;
                        end else if (!htx_q && rd_data) begin
                            scl_oe_q <= 1'b0;
                            cnt_q    <= 4'h0;
                            state_q  <= ST_RX;
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == BYTE_BITS) begin
                            rx_load_q <= 1'b1;
                            sda_oe_q  <= ~sent_ack_bit_q;
                            irq_q     <= 1'b1;
                            state_q   <= ST_RX_AK;
                        end
                    end
                    ST_RX_AK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            scl_oe_q <= 1'b1;
                            state_q  <= ST_STRETCH;
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_q == BYTE_BITS) begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_TX_AK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= ~shift_q[6];
                            end
                        end
                    end
                    ST_TX_AK: begin
                        if (scl_rise) begin
                            received_ack_status_q <= sda_s;
                        end else if (scl_fall) begin
                            irq_q <= 1'b1;
                            if (!received_ack_status_q) begin
                                scl_oe_q <= 1'b1;
                                state_q  <= ST_STRETCH;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_WAIT_SP;
                            end
                        end
                    end
                    ST_WAIT_SP: begin
                        sda_oe_q <= 1'b0;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // i2cto_top

/* File: test/i2cto_master.sv */
// Behavioural I2C bus master facing the slave
module i2cto_master (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Drive levels, high releases the line
    output logic     scl_o,
    output logic     sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idles released, clock standing high
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    // One 48 ns clock; waits while the slave stretches
    task automatic bit_io(input logic bv, output logic r);
        sda_o = bv;
        #12 scl_o = 1'h1;
        wait (scl);
        #12 r = sda;
        #12 scl_o = 1'h0;
        #12;
    endtask
    // Data falls while the clock stays high
    task automatic start();
        #24 sda_o = 1'h0;
        #24 scl_o = 1'h0;
        #12;
    endtask
    // eight bits, first bit most significant, low acknowledge
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] qd,
                        output logic ar);
        for (int i = 7; i >= 0; i--) bit_io(d[i], qd[i]);
        bit_io(ak, ar);
    endtask
    // Data rises while the clock stays high
    task automatic stop();
        sda_o = 1'h0;
        #12 scl_o = 1'h1;
        wait (scl);
        #24 sda_o = 1'h1;
        #24;
    endtask
endmodule // i2cto_master

/* File: test/i2cto_props.sv */
// Port assertions for the I2C slave time-out block
module i2cto_props import i2cto_pkg::*; (
    // Clock and reset
    input wire logic              MCLK,
    input wire logic              RESETN,
    // APB slave side
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // Pins and interrupt
    input wire logic              SCL_IN,
    input wire logic              SCL_OUT,
    input wire logic              SCL_OE,
    input wire logic              SDA_IN,
    input wire logic              SDA_OUT,
    input wire logic              SDA_OE,
    input wire logic              SUB_CLK,
    input wire logic              SIM_IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    // Setup cycle followed by the first access cycle
    sequence s_first_acc;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    // Completed access to the data register
    sequence s_data_acc;
        PSEL && PENABLE && PREADY && PADDR == OFF_DATA;
    endsequence
    a_ready_first: assert property (s_first_acc |-> PREADY) else $error("late ready");
    a_ready_once: assert property (PREADY |=> !PREADY) else $error("ready too long");
    a_err_only: assert property (PSLVERR |-> PREADY) else $error("stray error");
    a_err_map: assert property (PREADY && PADDR > OFF_TOC |-> PSLVERR) else $error("no error");
    a_err_none: assert property (PREADY && PADDR == OFF_TOC |-> !PSLVERR) else $error("bad error");
    a_rdata_high: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits");
    // Open drain: the pins are only ever pulled low
    a_pins_low: assert property (!SCL_OUT && !SDA_OUT) else $error("pin driven high");
    a_irq_pulse: assert property (SIM_IRQ |=> !SIM_IRQ) else $error("irq too long");
    a_stretch_free: assert property (SCL_OE ##0 s_data_acc |-> ##[1:6] !SCL_OE)
        else $error("stretch kept");
    // Data line only moves while the clock line is low
    a_sda_quiet: assert property ($changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2))
        else $error("sda moved at clock high");
endmodule // i2cto_props

bind i2cto_top i2cto_props u_props (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SUB_CLK(SUB_CLK), .SIM_IRQ(SIM_IRQ));

/* File: test/i2cto_tb_top.sv */
// Self-checking bench for the I2C slave time-out block
module i2cto_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import i2cto_pkg::*;
    logic        mclk = 1'h0, resetn = 1'h0, sub_clk = 1'h0, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, scl_oe, sda_oe, pready, pslverr, sim_irq, a, e, seen;
    logic [7:0]  paddr = 8'h00, b;
    logic [31:0] pwdata = 32'h0, prdata, q;
    wire         scl_w, sda_w, mst_scl, mst_sda;
    int          miscompares = 0, n_checks = 0, n;
    // Core clock and a sub-oscillator ten times slower, its edges on core clock falls
    always #2 mclk = ~mclk;
    always #20 sub_clk = ~sub_clk;
    // Pulled-up wires: low when either party pulls
    assign scl_w = mst_scl & ~scl_oe;
    assign sda_w = mst_sda & ~sda_oe;
    i2cto_top i_dut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SCL_IN(scl_w), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda_w),
        .SDA_OUT(), .SDA_OE(sda_oe), .SUB_CLK(sub_clk), .SIM_IRQ(sim_irq));
    i2cto_master i_mst (.scl(scl_w), .sda(sda_w), .scl_o(mst_scl), .sda_o(mst_sda));
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, s, x);
        end
    endtask
    // One transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] x);
        apb(1'h0, ad, 32'h0);
        chk(q & m, x);
    endtask
    task automatic t_regs();
        rdc(OFF_TOC, 32'hFF, 32'h00);
        apb(1'h1, OFF_TOC, 32'hA5);
        rdc(OFF_TOC, 32'hFF, 32'hA5);
        apb(1'h1, OFF_TOC, 32'h00);
        apb(1'h0, 8'h20, 32'h0);
        chk({q[31:1], e}, 32'h1);
        apb(1'h1, OFF_ADDR, 32'hA4);
        apb(1'h1, OFF_CTL0, 32'h01);
        $display("registers test done");
    endtask
    // Master writes one byte; the dummy read releases the stretch
    // Shortest time-out armed: only STOP keeps it from firing afterwards
    task automatic t_rx();
        apb(1'h1, OFF_TOC, 32'h80);
        i_mst.start();
        i_mst.xfer(8'hA4, 1'h1, b, a);
        chk({31'h0, a}, 32'h0);
        rdc(OFF_CTL1, 32'h44, 32'h40);
        chk({31'h0, scl_oe}, 32'h1);
        apb(1'h0, OFF_DATA, 32'h0);
        i_mst.xfer(8'h96, 1'h1, b, a);
        chk({31'h0, a}, 32'h0);
        rdc(OFF_DATA, 32'hFF, 32'h96);
        i_mst.stop();
        repeat (400) @(posedge mclk);
        rdc(OFF_TOC, 32'hC0, 32'h80);
        $display("receive test done");
    endtask
    // Master reads two bytes, acknowledging only the first
    task automatic t_tx();
        i_mst.start();
        i_mst.xfer(8'hA5, 1'h1, b, a);
        rdc(OFF_CTL1, 32'h44, 32'h44);
        apb(1'h1, OFF_CTL1, 32'h08);
        apb(1'h1, OFF_DATA, 32'h3C);
        i_mst.xfer(8'hFF, 1'h0, b, a);
        chk({24'h0, b}, 32'h3C);
        rdc(OFF_CTL1, 32'h01, 32'h00);
        apb(1'h1, OFF_DATA, 32'hC3);
        i_mst.xfer(8'hFF, 1'h1, b, a);
        chk({24'h0, b}, 32'hC3);
        rdc(OFF_CTL1, 32'h01, 32'h01);
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        i_mst.stop();
        $display("transmit test done");
    endtask
    // Stretch with no service until the time-out fires
    task automatic t_tout();
        apb(1'h1, OFF_TOC, 32'h81);
        i_mst.start();
        i_mst.xfer(8'hA4, 1'h1, b, a);
        seen = 1'h0;
        n = 0;
        while (!seen && n < 2000) begin
            @(posedge mclk);
            n++;
            seen = (n > 20) && (sim_irq === 1'h1);
        end
        chk({31'h0, seen}, 32'h1);
        chk({31'h0, n * 4 > 2500 && n * 4 < 4000}, 32'h1);
        rdc(OFF_TOC, 32'hFF, 32'h41);
        rdc(OFF_CTL1, 32'h4E, 32'h00);
        rdc(OFF_ADDR, 32'hFF, 32'hA4);
        chk({31'h0, scl_oe}, 32'h0);
        apb(1'h1, OFF_TOC, 32'h00);
        rdc(OFF_TOC, 32'hFF, 32'h00);
        i_mst.stop();
        $display("time-out test done");
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'h1;
        t_regs();
        t_rx();
        t_tx();
        t_tout();
        stop_test();
    end
    // Watchdog well beyond the expected 8 us of traffic
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule // i2cto_tb_top
